// *** cma_pkg.sv ***
// shared constants, types and address helpers for the core memory map
package cma_pkg;
   localparam logic [7:0] STKPTR_ADDR = 8'h81;
   localparam logic [7:0] STAT_ADDR = 8'hd0;
   localparam logic [7:0] PSC_ADDR = 8'h8f;
   localparam logic [7:0] STKPTR_RESET = 8'h07;
   localparam logic [7:0] STAT_RESET = 8'h00;
   localparam logic [7:0] PSC_RESET = 8'h00;
   localparam int BANK_LO_POS = 3;
   localparam int BANK_HI_POS = 4;
   localparam int PSWE_POS = 0;
   localparam logic [7:0] BIT_BASE = 8'h20;
   localparam logic [15:0] FLASH_TOP_16K = 16'h3fff;
   localparam logic [15:0] FLASH_TOP_8K = 16'h1fff;
   localparam logic [15:0] RESERVED_FROM = 16'h3e00;
   localparam int RAM_DEPTH = 256;

   typedef enum logic [2:0] {
      CMA_DIRECT = 3'b000,
      CMA_INDIRECT = 3'b001,
      CMA_WREG = 3'b010,
      CMA_BIT = 3'b011,
      CMA_PUSH = 3'b100,
      CMA_POP = 3'b101
   } cma_kind_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_PTR = 2'b01,
      ST_ACC = 2'b10
   } cma_state_t;

   // ram address of working register n in the given bank
   function automatic logic [7:0] cmaBankAddr(input logic [1:0] bank, input logic [2:0] n);
      return {3'b000, bank, n};
   endfunction : cmaBankAddr

   // byte holding a bit address: 0x20..0x2f below 0x80, x0/x8 special registers above
   function automatic logic [7:0] cmaBitByte(input logic [7:0] a);
      return a[7] ? {a[7:3], 3'b000} : (BIT_BASE | {4'h0, a[6:3]});
   endfunction : cmaBitByte
endpackage : cma_pkg

// *** cma_ram_if.sv ***
// single-port internal data ram connection
`timescale 1ns/1ns
interface cma_ram_if;
   logic en;
   logic we;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport master (output en, output we, output addr, output wdata, input rdata);
   modport slave (input en, input we, input addr, input wdata, output rdata);
endinterface : cma_ram_if

// *** cma_ram.sv ***
// 256-byte internal data ram, synchronous read
`timescale 1ns/1ns
module cma_ram import cma_pkg::*; #(
   parameter int DEPTH = RAM_DEPTH
) (
   input wire logic mclk,
   cma_ram_if.slave rif
);
   logic [7:0] mem [DEPTH];

   // read returns the old byte on a simultaneous write
   always_ff @(posedge mclk) begin
      if (rif.en) begin
         if (rif.we) begin
            mem[rif.addr] <= rif.wdata;
         end
         rif.rdata <= mem[rif.addr];
      end
   end
endmodule : cma_ram

// *** cma_prog_decode.sv ***
// program memory range and write-permission decode
`timescale 1ns/1ns
module cma_prog_decode import cma_pkg::*; #(
   parameter logic [15:0] FLASH_TOP = FLASH_TOP_16K
) (
   input wire logic [15:0] progAddr,
   input wire logic progWrite,
   input wire logic storeWriteEn,
   output logic inFlash,
   output logic reservedHit,
   output logic writeOk
);
   always_comb begin
      inFlash = (progAddr <= FLASH_TOP);
      // only the large variant reaches the reserved tail
      reservedHit = (FLASH_TOP == FLASH_TOP_16K) && (progAddr >= RESERVED_FROM);
      writeOk = progWrite && storeWriteEn && inFlash;
   end
endmodule : cma_prog_decode

// *** core_memory_address_map.sv ***
// data/program memory decoding, working banks, bit space and stack for the core
`timescale 1ns/1ns
// Contract
// - 64k program space, separate from data
// - flash from 0x0000 to variant top
// - program writes only with store-enable bit
// - 256 bytes internal ram at 0x00-0xff
// - lower 128 bytes direct and indirect
// - above 0x7f: direct special regs, indirect ram
// - four banks of eight working registers
// - indirect pointer from active register 0/1
// - bytes 0x20-0x2f hold bits 0x00-0x7f
// - bit or byte chosen by instruction kind
// - stack pointer at direct address 0x81
// - push writes at pointer+1, then increments
// - reset loads stack pointer with 0x07
// - stack always in internal ram
// - only x0/x8 special regs bit addressable
module core_memory_address_map import cma_pkg::*; #(
   parameter logic [15:0] FLASH_TOP = FLASH_TOP_16K
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic accValid,
   output logic accReady,
   input wire cma_kind_t accKind,
   input wire logic [7:0] accAddr,
   input wire logic accWrite,
   input wire logic [7:0] accWdata,
   input wire logic accBitVal,
   output logic accDone,
   output logic [7:0] rdData,
   output logic rdBit,
   output logic sfrSel,
   output logic sfrWe,
   output logic [7:0] sfrAddr,
   output logic [7:0] sfrWdata,
   input wire logic [7:0] sfrRdata,
   input wire logic progValid,
   input wire logic progWrite,
   input wire logic [15:0] progAddr,
   input wire logic [7:0] progWdata,
   output logic flashRd,
   output logic flashWe,
   output logic [15:0] flashAddr,
   output logic [7:0] flashWdata,
   output logic progFault,
   output logic progReserved,
   output logic [7:0] stackPointer,
   output logic [7:0] statusWord
);
   cma_ram_if rif ();

   cma_ram #(.DEPTH(RAM_DEPTH)) u_ram (
      .mclk(mclk),
      .rif(rif)
   );

   logic inFlash;
   logic reservedHit;
   logic writeOk;
   logic [7:0] psc, next_psc;

   cma_prog_decode #(.FLASH_TOP(FLASH_TOP)) u_prog (
      .progAddr(progAddr),
      .progWrite(progWrite),
      .storeWriteEn(psc[PSWE_POS]),
      .inFlash(inFlash),
      .reservedHit(reservedHit),
      .writeOk(writeOk)
   );

   cma_state_t state, next_state;
   logic [7:0] stkPtr, next_stkPtr;
   logic [7:0] statReg, next_statReg;
   cma_kind_t kindQ, next_kindQ;
   logic writeQ, next_writeQ;
   logic [7:0] wdataQ, next_wdataQ;
   logic bitValQ, next_bitValQ;
   logic [2:0] bitPosQ, next_bitPosQ;
   logic [7:0] eaQ, next_eaQ;
   logic toSfrQ, next_toSfrQ;
   logic [7:0] next_rdData;
   logic next_rdBit;
   logic next_accDone;
   logic taken;
   logic [1:0] bank;
   logic [7:0] srcByte;
   logic [7:0] mergedByte;
   logic internalSfr;

   assign accReady = (state == ST_IDLE);
   assign taken = accValid && accReady;
   assign bank = {statReg[BANK_HI_POS], statReg[BANK_LO_POS]};
   assign internalSfr = (eaQ == STKPTR_ADDR) || (eaQ == STAT_ADDR) || (eaQ == PSC_ADDR);
   assign sfrAddr = eaQ;
   assign stackPointer = stkPtr;
   assign statusWord = statReg;

   // byte seen in the access cycle, from ram or from the special register space
   always_comb begin
      srcByte = rif.rdata;
      if (toSfrQ) begin
         unique case (eaQ)
            STKPTR_ADDR: srcByte = stkPtr;
            STAT_ADDR: srcByte = statReg;
            PSC_ADDR: srcByte = psc;
            default: srcByte = sfrRdata;
         endcase
      end
      mergedByte = srcByte;
      mergedByte[bitPosQ] = bitValQ;
   end

   always_comb begin
      sfrSel = (state == ST_ACC) && toSfrQ && !internalSfr;
      sfrWe = sfrSel && writeQ;
      sfrWdata = (kindQ == CMA_BIT) ? mergedByte : wdataQ;
   end

   always_comb begin
      next_state = state;
      next_stkPtr = stkPtr;
      next_statReg = statReg;
      next_psc = psc;
      next_kindQ = kindQ;
      next_writeQ = writeQ;
      next_wdataQ = wdataQ;
      next_bitValQ = bitValQ;
      next_bitPosQ = bitPosQ;
      next_eaQ = eaQ;
      next_toSfrQ = toSfrQ;
      next_rdData = rdData;
      next_rdBit = rdBit;
      next_accDone = 1'b0;
      rif.en = 1'b0;
      rif.we = 1'b0;
      rif.addr = 8'h00;
      rif.wdata = accWdata;
      unique case (state)
         ST_IDLE: begin
            if (taken) begin
               next_kindQ = accKind;
               next_writeQ = accWrite;
               next_wdataQ = accWdata;
               next_bitValQ = accBitVal;
               next_bitPosQ = accAddr[2:0];
               next_toSfrQ = 1'b0;
               next_state = ST_ACC;
               unique case (accKind)
                  CMA_DIRECT: begin
                     next_eaQ = accAddr;
                     next_toSfrQ = accAddr[7];
                     rif.en = !accAddr[7];
                     rif.we = !accAddr[7] && accWrite;
                     rif.addr = accAddr;
                  end
                  CMA_WREG: begin
                     next_eaQ = cmaBankAddr(bank, accAddr[2:0]);
                     rif.en = 1'b1;
                     rif.we = accWrite;
                     rif.addr = cmaBankAddr(bank, accAddr[2:0]);
                  end
                  CMA_INDIRECT: begin
                     rif.en = 1'b1;
                     rif.addr = cmaBankAddr(bank, {2'b00, accAddr[0]});
                     next_state = ST_PTR;
                  end
                  CMA_BIT: begin
                     // bit writes are read-modify-write: fetch the byte first
                     next_eaQ = cmaBitByte(accAddr);
                     next_toSfrQ = accAddr[7];
                     rif.en = !accAddr[7];
                     rif.addr = cmaBitByte(accAddr);
                  end
                  CMA_PUSH: begin
                     next_eaQ = stkPtr + 8'h01;
                     next_writeQ = 1'b1;
                     rif.en = 1'b1;
                     rif.we = 1'b1;
                     rif.addr = stkPtr + 8'h01;
                     next_stkPtr = stkPtr + 8'h01;
                  end
                  CMA_POP: begin
                     next_eaQ = stkPtr;
                     next_writeQ = 1'b0;
                     rif.en = 1'b1;
                     rif.addr = stkPtr;
                     next_stkPtr = stkPtr - 8'h01;
                  end
                  default: begin
                     // unused kind codes complete as a harmless no-op
                     next_eaQ = 8'h00;
                     next_writeQ = 1'b0;
                  end
               endcase
            end
         end
         ST_PTR: begin
            // pointer byte is in ram output; upper half is ram, never special regs
            next_eaQ = rif.rdata;
            rif.en = 1'b1;
            rif.we = writeQ;
            rif.wdata = wdataQ;
            rif.addr = rif.rdata;
            next_state = ST_ACC;
         end
         ST_ACC: begin
            next_rdData = srcByte;
            next_rdBit = srcByte[bitPosQ];
            next_accDone = 1'b1;
            next_state = ST_IDLE;
            if (kindQ == CMA_BIT && writeQ && !toSfrQ) begin
               rif.en = 1'b1;
               rif.we = 1'b1;
               rif.addr = eaQ;
               rif.wdata = mergedByte;
            end
            if (toSfrQ && writeQ) begin
               unique case (eaQ)
                  STKPTR_ADDR: next_stkPtr = sfrWdata;
                  STAT_ADDR: next_statReg = sfrWdata;
                  PSC_ADDR: next_psc = sfrWdata;
                  default: next_stkPtr = stkPtr;
               endcase
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         state <= ST_IDLE;
         stkPtr <= STKPTR_RESET;
         statReg <= STAT_RESET;
         psc <= PSC_RESET;
         kindQ <= CMA_DIRECT;
         writeQ <= 1'b0;
         wdataQ <= 8'h00;
         bitValQ <= 1'b0;
         bitPosQ <= 3'h0;
         eaQ <= 8'h00;
         toSfrQ <= 1'b0;
         rdData <= 8'h00;
         rdBit <= 1'b0;
         accDone <= 1'b0;
      end else begin
         state <= next_state;
         stkPtr <= next_stkPtr;
         statReg <= next_statReg;
         psc <= next_psc;
         kindQ <= next_kindQ;
         writeQ <= next_writeQ;
         wdataQ <= next_wdataQ;
         bitValQ <= next_bitValQ;
         bitPosQ <= next_bitPosQ;
         eaQ <= next_eaQ;
         toSfrQ <= next_toSfrQ;
         rdData <= next_rdData;
         rdBit <= next_rdBit;
         accDone <= next_accDone;
      end
   end

   // program side: one registered stage toward the flash array
   logic next_flashRd, next_flashWe, next_progFault, next_progReserved;
   logic [15:0] next_flashAddr;
   logic [7:0] next_flashWdata;

   always_comb begin
      next_flashRd = progValid && !progWrite && inFlash;
      next_flashWe = progValid && writeOk;
      next_flashAddr = progValid ? progAddr : flashAddr;
      next_flashWdata = progValid ? progWdata : flashWdata;
      // write without the enable bit, or outside the flash block, is refused
      next_progFault = progValid && (!inFlash || (progWrite && !writeOk));
      next_progReserved = progValid && reservedHit;
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         flashRd <= 1'b0;
         flashWe <= 1'b0;
         flashAddr <= 16'h0000;
         flashWdata <= 8'h00;
         progFault <= 1'b0;
         progReserved <= 1'b0;
      end else begin
         flashRd <= next_flashRd;
         flashWe <= next_flashWe;
         flashAddr <= next_flashAddr;
         flashWdata <= next_flashWdata;
         progFault <= next_progFault;
         progReserved <= next_progReserved;
      end
   end

   a_stack_reset_value: assert property (@(posedge mclk) !nrst |=> stkPtr == 8'h07)
      else $error("stack pointer not 0x07 after reset");
   a_push_addr_inc: assert property (@(posedge mclk) disable iff (!nrst)
      taken && accKind == CMA_PUSH |-> rif.we && rif.addr == stkPtr + 8'h01
      ##1 stkPtr == $past(rif.addr))
      else $error("push did not write at pointer plus one");
   a_pop_read_dec: assert property (@(posedge mclk) disable iff (!nrst)
      taken && accKind == CMA_POP |-> rif.en && !rif.we && rif.addr == stkPtr
      ##1 stkPtr == $past(stkPtr) - 8'h01 ##1 rdData == $past(rif.rdata))
      else $error("pop did not read at pointer and decrement");
   a_bank_reg_addr: assert property (@(posedge mclk) disable iff (!nrst)
      taken && accKind == CMA_WREG |-> rif.addr == {3'b000, statReg[4:3], accAddr[2:0]})
      else $error("working register mapped to wrong bank");
   a_direct_upper_sfr: assert property (@(posedge mclk) disable iff (!nrst)
      taken && accKind == CMA_DIRECT && accAddr[7] |-> !rif.en ##1 !rif.en && toSfrQ)
      else $error("direct upper access reached ram");
   a_indirect_ram_only: assert property (@(posedge mclk) disable iff (!nrst)
      taken && accKind == CMA_INDIRECT |-> rif.addr[7:1] == {3'b000, statReg[4:3], 2'b00}
      ##1 rif.en && !sfrSel ##1 !sfrSel ##1 accDone)
      else $error("indirect access not through register 0/1 into ram");
   a_bit_byte_map: assert property (@(posedge mclk) disable iff (!nrst)
      taken && accKind == CMA_BIT && !accAddr[7] |-> rif.addr == 8'h20 + {4'h0, accAddr[6:3]}
      ##2 accDone && rdBit == $past(rif.rdata[bitPosQ]))
      else $error("bit address mapped to wrong byte or bit");
   a_bit_sfr_align: assert property (@(posedge mclk) disable iff (!nrst)
      taken && accKind == CMA_BIT && accAddr[7] |=> eaQ[2:0] == 3'b000 && toSfrQ)
      else $error("high bit address not on x0/x8 register");
   a_prog_write_gate: assert property (@(posedge mclk) disable iff (!nrst)
      progValid && progWrite && !psc[0] |=> !flashWe && progFault)
      else $error("program write without store enable");
   a_done_latency: assert property (@(posedge mclk) disable iff (!nrst)
      taken && accKind != CMA_INDIRECT |=> !accReady ##1 accDone && accReady)
      else $error("access not answered two cycles after acceptance");
   a_stack_in_ram: assert property (@(posedge mclk) disable iff (!nrst)
      taken && (accKind == CMA_PUSH || accKind == CMA_POP) |-> rif.en ##1 !toSfrQ && !sfrSel)
      else $error("stack access left internal ram");
   a_flash_top_fault: assert property (@(posedge mclk) disable iff (!nrst)
      progValid && progAddr > FLASH_TOP |=> progFault && !flashRd && !flashWe)
      else $error("program access beyond flash top not refused");
endmodule : core_memory_address_map

// *** cma_sfr_model.sv ***
// behavioural model of the peripheral special registers behind the core memory map
`timescale 1ns/1ns
module cma_sfr_model (
   input wire logic mclk,
   input wire logic sfrSel,
   input wire logic sfrWe,
   input wire logic [7:0] sfrAddr,
   input wire logic [7:0] sfrWdata,
   output logic [7:0] sfrRdata
);
   logic [7:0] regs [256];

   // every address holds a register, so the bench never reads a reserved hole
   initial begin
      for (int i = 0; i < 256; i++) begin
         regs[i] = 8'(i) ^ 8'h3c;
      end
   end

   // unselected bus shows the inverse, so a stale value never passes for a read
   assign sfrRdata = sfrSel ? regs[sfrAddr] : ~regs[sfrAddr];

   always @(posedge mclk) begin
      if (sfrSel && sfrWe) begin
         regs[sfrAddr] <= sfrWdata;
      end
   end
endmodule : cma_sfr_model

// *** tb_core_memory_address_map.sv ***
// self-checking bench for the core memory map
`timescale 1ns/1ns
module tb_core_memory_address_map import cma_pkg::*;;
   logic mclk, nrst, accValid, accWrite, accBitVal, progValid, progWrite;
   logic accReady, accDone, rdBit, sfrSel, sfrWe, flashRd, flashWe, progFault, progReserved;
   cma_kind_t accKind;
   logic [7:0] accAddr, accWdata, progWdata, rdData, sfrAddr, sfrWdata, sfrRdata;
   logic [7:0] stackPointer, statusWord, flashWdata, got;
   logic [15:0] progAddr, flashAddr;
   logic gotBit;
   int error_cnt, total_checks, cyc;

   core_memory_address_map #(.FLASH_TOP(16'h3fff)) dut_u (.mclk(mclk), .nrst(nrst),
      .accValid(accValid), .accReady(accReady), .accKind(accKind), .accAddr(accAddr),
      .accWrite(accWrite), .accWdata(accWdata), .accBitVal(accBitVal), .accDone(accDone),
      .rdData(rdData), .rdBit(rdBit), .sfrSel(sfrSel), .sfrWe(sfrWe), .sfrAddr(sfrAddr),
      .sfrWdata(sfrWdata), .sfrRdata(sfrRdata), .progValid(progValid),
      .progWrite(progWrite), .progAddr(progAddr), .progWdata(progWdata),
      .flashRd(flashRd), .flashWe(flashWe), .flashAddr(flashAddr),
      .flashWdata(flashWdata), .progFault(progFault), .progReserved(progReserved),
      .stackPointer(stackPointer), .statusWord(statusWord));

   cma_sfr_model sfr_u (.mclk(mclk), .sfrSel(sfrSel), .sfrWe(sfrWe), .sfrAddr(sfrAddr),
      .sfrWdata(sfrWdata), .sfrRdata(sfrRdata));

   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   task test_done;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : test_done

   task chk8(input string what, input logic [7:0] exp, input logic [7:0] seen);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk8

   task chk1(input string what, input logic exp, input logic seen);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %b seen %b", what, exp, seen);
      end
   endtask : chk1

   task chk16(input string what, input logic [15:0] exp, input logic [15:0] seen);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk16

   // one data access; the answer latency is checked against the engine's fixed timing
   task acc(input cma_kind_t k, input logic [7:0] a, input logic w, input logic [7:0] d,
      input logic b);
      int n;
      @(posedge mclk);
      accValid <= 1'b1;
      accKind <= k;
      accAddr <= a;
      accWrite <= w;
      accWdata <= d;
      accBitVal <= b;
      // hold the request until an edge that finds the engine idle
      @(negedge mclk);
      while (accReady !== 1'b1) begin
         @(negedge mclk);
      end
      @(posedge mclk);
      accValid <= 1'b0;
      n = 0;
      do begin
         @(negedge mclk);
         n++;
      end while (accDone !== 1'b1 && n < 10);
      chk8("answer latency", (k == CMA_INDIRECT) ? 8'h03 : 8'h02, 8'(n));
      chk1("ready with answer", 1'b1, accReady);
      got = rdData;
      gotBit = rdBit;
   endtask : acc

   task prog(input logic w, input logic [15:0] a, input logic [7:0] d);
      @(posedge mclk);
      progValid <= 1'b1;
      progWrite <= w;
      progAddr <= a;
      progWdata <= d;
      @(posedge mclk);
      progValid <= 1'b0;
      @(negedge mclk);
   endtask : prog

   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         error_cnt++;
         test_done;
      end
   end

   initial begin
      error_cnt = 0;
      total_checks = 0;
      nrst = 1'b0;
      accValid = 1'b0;
      accKind = CMA_DIRECT;
      accAddr = 8'h00;
      accWrite = 1'b0;
      accWdata = 8'h00;
      accBitVal = 1'b0;
      progValid = 1'b0;
      progWrite = 1'b0;
      progAddr = 16'h0000;
      progWdata = 8'h00;
      repeat (6) @(posedge mclk);
      nrst <= 1'b1;
      @(negedge mclk);
      chk8("stack pointer", 8'h07, stackPointer);
      acc(CMA_DIRECT, 8'h81, 1'b0, 8'h00, 1'b0);
      chk8("stack pointer read", 8'h07, got);
      acc(CMA_PUSH, 8'h00, 1'b0, 8'h5a, 1'b0);
      chk8("stack pointer", 8'h08, stackPointer);
      acc(CMA_DIRECT, 8'h08, 1'b0, 8'h00, 1'b0);
      chk8("first push byte", 8'h5a, got);
      acc(CMA_POP, 8'h00, 1'b0, 8'h00, 1'b0);
      chk8("pop byte", 8'h5a, got);
      chk8("stack pointer", 8'h07, stackPointer);
      // stack placed in the upper half, clear of the banks, must land in ram
      acc(CMA_DIRECT, 8'h81, 1'b1, 8'h7f, 1'b0);
      acc(CMA_PUSH, 8'h00, 1'b0, 8'h11, 1'b0);
      chk8("stack pointer", 8'h80, stackPointer);
      acc(CMA_WREG, 8'h00, 1'b1, 8'h80, 1'b0);
      acc(CMA_INDIRECT, 8'h00, 1'b0, 8'h00, 1'b0);
      chk8("upper ram stack byte", 8'h11, got);
      acc(CMA_DIRECT, 8'h80, 1'b0, 8'h00, 1'b0);
      chk8("special register 0x80", 8'hbc, got);
      acc(CMA_POP, 8'h00, 1'b0, 8'h00, 1'b0);
      chk8("pop byte", 8'h11, got);
      for (int b = 0; b < 4; b++) begin
         acc(CMA_DIRECT, 8'hd0, 1'b1, 8'(b << 3), 1'b0);
         chk8("status word", 8'(b << 3), statusWord);
         acc(CMA_WREG, 8'h03, 1'b1, 8'(8'h40 + b), 1'b0);
         acc(CMA_DIRECT, 8'(b * 8 + 3), 1'b0, 8'h00, 1'b0);
         chk8("bank register", 8'(8'h40 + b), got);
      end
      // bank 3 active now; bank 0 register 0 still holds a different pointer
      acc(CMA_WREG, 8'h00, 1'b1, 8'h90, 1'b0);
      acc(CMA_INDIRECT, 8'h00, 1'b1, 8'hc3, 1'b0);
      acc(CMA_DIRECT, 8'h90, 1'b0, 8'h00, 1'b0);
      chk8("direct 0x90", 8'hac, got);
      acc(CMA_INDIRECT, 8'h00, 1'b0, 8'h00, 1'b0);
      chk8("indirect 0x90", 8'hc3, got);
      acc(CMA_WREG, 8'h01, 1'b1, 8'h45, 1'b0);
      acc(CMA_INDIRECT, 8'h01, 1'b1, 8'h77, 1'b0);
      acc(CMA_DIRECT, 8'h45, 1'b0, 8'h00, 1'b0);
      chk8("direct 0x45", 8'h77, got);
      acc(CMA_DIRECT, 8'h22, 1'b1, 8'h00, 1'b0);
      acc(CMA_BIT, 8'h13, 1'b1, 8'h00, 1'b1);
      acc(CMA_DIRECT, 8'h22, 1'b0, 8'h00, 1'b0);
      chk8("byte 0x22", 8'h08, got);
      acc(CMA_BIT, 8'h13, 1'b0, 8'h00, 1'b0);
      chk1("bit 0x13", 1'b1, gotBit);
      acc(CMA_BIT, 8'h91, 1'b1, 8'h00, 1'b1);
      acc(CMA_DIRECT, 8'h90, 1'b0, 8'h00, 1'b0);
      chk8("special register 0x90", 8'hae, got);
      acc(CMA_BIT, 8'h97, 1'b0, 8'h00, 1'b0);
      chk1("bit 0x97", 1'b1, gotBit);
      prog(1'b0, 16'h1000, 8'h00);
      chk1("flash read", 1'b1, flashRd);
      chk1("program fault", 1'b0, progFault);
      prog(1'b0, 16'h3e10, 8'h00);
      chk1("reserved flag", 1'b1, progReserved);
      prog(1'b0, 16'h4000, 8'h00);
      chk1("program fault", 1'b1, progFault);
      prog(1'b1, 16'h1000, 8'ha5);
      chk1("flash write", 1'b0, flashWe);
      chk1("program fault", 1'b1, progFault);
      acc(CMA_DIRECT, 8'h8f, 1'b1, 8'h01, 1'b0);
      prog(1'b1, 16'h1234, 8'ha5);
      chk1("flash write", 1'b1, flashWe);
      chk16("flash address", 16'h1234, flashAddr);
      chk8("flash data", 8'ha5, flashWdata);
      @(posedge mclk);
      nrst <= 1'b0;
      @(posedge mclk);
      nrst <= 1'b1;
      @(negedge mclk);
      chk8("stack pointer", 8'h07, stackPointer);
      chk8("status word", 8'h00, statusWord);
      acc(CMA_DIRECT, 8'h81, 1'b0, 8'h00, 1'b0);
      chk8("stack pointer read", 8'h07, got);
      test_done;
   end
endmodule : tb_core_memory_address_map
